// ### core/wk_pkg.sv
// What this block does
// - Scan code register at 0x5F, standby reset
// - Key match status/enable at bit 5
// - Frame starts after clock high 115us or longer
// - Sample data on each keyboard clock fall after the start edge
// - Compare data byte after ninth falling edge
// - Data plus parity must hold odd ones
// - Match, parity, stop one set status bit
// - Back to idle after 11 clocks, repeat
// - Clock high too long mid-frame abandons frame
// - Config bit 0 picks external or derived clock
// - Standby power uses only external slow clock
// - Config bit 1 stops matcher when set
// - Wake from key only when enabled
// - Wake output needs global enable; summary ignores it
// - Summary clears only after all sources clear
package wk_pkg;

  localparam logic [7:0] WK_SCAN_CODE_OFS   = 8'h5f;
  localparam logic [7:0] WK_SLOW_CFG_OFS    = 8'hf0;
  localparam logic [7:0] WK_SCAN_CODE_RST   = 8'h00;
  localparam logic [1:0] WK_SLOW_CFG_RST    = 2'h0;
  localparam int         WK_CFG_EXT_BIT     = 0;
  localparam int         WK_CFG_OFF_BIT     = 1;
  localparam int         WK_STATUS_KEY_BIT  = 5;

  localparam int         WK_CORE_CLK_HZ     = 25000000;
  localparam int         WK_SLOW_CLK_HZ     = 32768;
  localparam int         WK_INT_DIV         = WK_CORE_CLK_HZ / WK_SLOW_CLK_HZ;
  localparam int         WK_SLOW_PERIOD_NS  = 1000000000 / WK_SLOW_CLK_HZ;
  localparam int         WK_IDLE_HIGH_MIN_US = 115;
  localparam int         WK_IDLE_HIGH_MAX_US = 145;
  // Least time rounds up, longest time rounds down
  localparam int         WK_IDLE_HIGH_TICKS =
    (WK_IDLE_HIGH_MIN_US * 1000 + WK_SLOW_PERIOD_NS - 1) / WK_SLOW_PERIOD_NS;
  localparam int         WK_ABORT_HIGH_TICKS =
    (WK_IDLE_HIGH_MAX_US * 1000) / WK_SLOW_PERIOD_NS;
  localparam logic [3:0] WK_FRAME_BITS      = 4'hb;
  localparam logic [3:0] WK_PARITY_EDGE     = 4'ha;
  localparam logic [3:0] WK_LAST_DATA_EDGE  = 4'h9;

  typedef enum logic [1:0] {WK_IDLE, WK_ARMED, WK_RECV} wk_state_t;

endpackage : wk_pkg

// ### core/wk_slow_tick.sv
`timescale 1ns/100ps
`default_nettype none
module wk_slow_tick #(
  parameter int DIV = wk_pkg::WK_INT_DIV
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic ext_slow_clk,
  input  wire logic use_ext,
  input  wire logic run,
  output logic      tick
);

  logic        ext_meta_q;
  logic        ext_sync_q;
  logic        ext_prev_q;
  logic [15:0] div_cnt_q;
  logic        int_tick;
  logic        ext_tick;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      ext_meta_q <= ext_slow_clk;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  // Divider idles while stopped so it adds no switching in the off state
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      div_cnt_q <= 16'h0000;
    else if (!run || use_ext || div_cnt_q == 16'((DIV) - 1))
      div_cnt_q <= 16'h0000;
    else
      div_cnt_q <= div_cnt_q + 16'h0001;
  end

  assign int_tick = !use_ext && div_cnt_q == 16'((DIV) - 1);
  assign ext_tick = use_ext && ext_sync_q && !ext_prev_q;
  assign tick     = run && (int_tick || ext_tick);

endmodule : wk_slow_tick
`default_nettype wire

// ### core/wk_matcher.sv
`timescale 1ns/100ps
`default_nettype none
module wk_matcher (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wr_data,
  input  wire logic       reg_rd_en,
  output logic      [7:0] reg_rd_data,
  input  wire logic       kbd_clk_in,
  input  wire logic       kbd_data_in,
  input  wire logic       ext_slow_clk,
  input  wire logic       main_power_present,
  input  wire logic       key_wake_enable,
  input  wire logic       key_status_clear,
  input  wire logic       other_wake_pending,
  input  wire logic       wake_global_enable,
  input  wire logic       summary_clear,
  output logic            key_match_status,
  output logic            wake_summary_status,
  output logic            wake_event_out
);

  logic [7:0]        scan_code_q;
  logic [1:0]        slow_cfg_q;
  logic [7:0]        rd_data_q;
  logic              kclk_meta_q;
  logic              kclk_sync_q;
  logic              kdat_meta_q;
  logic              kdat_sync_q;
  logic              kclk_s_q;
  logic              kdat_s_q;
  logic              kclk_prev_q;
  logic [3:0]        high_cnt_q;
  logic [3:0]        edge_cnt_q;
  logic [7:0]        data_q;
  logic              byte_match_q;
  logic              parity_q;
  wk_pkg::wk_state_t state_q;
  logic              key_status_q;
  logic              summary_q;
  logic              wake_q;
  logic              tick;
  logic              use_ext;
  logic              run;
  logic              code_wr;
  logic              fall;
  logic              frame_ok;
  logic              key_pending;

  assign use_ext = slow_cfg_q[wk_pkg::WK_CFG_EXT_BIT] || !main_power_present;
  assign run     = !slow_cfg_q[wk_pkg::WK_CFG_OFF_BIT];
  assign code_wr = reg_wr_en && reg_addr == wk_pkg::WK_SCAN_CODE_OFS;

  wk_slow_tick #(
    .DIV (wk_pkg::WK_INT_DIV)
  ) u_tick (
    .core_clk     (core_clk),
    .rst          (rst),
    .ext_slow_clk (ext_slow_clk),
    .use_ext      (use_ext),
    .run          (run),
    .tick         (tick)
  );

  // Registers live on standby power: only the standby reset clears them
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      scan_code_q <= wk_pkg::WK_SCAN_CODE_RST;
      slow_cfg_q  <= wk_pkg::WK_SLOW_CFG_RST;
    end
    else if (reg_wr_en)
    begin
      if (reg_addr == wk_pkg::WK_SCAN_CODE_OFS)
        scan_code_q <= reg_wr_data;
      else if (reg_addr == wk_pkg::WK_SLOW_CFG_OFS)
        slow_cfg_q  <= reg_wr_data[1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rd_data_q <= 8'h00;
    else if (reg_rd_en)
    begin
      unique case (reg_addr)
        wk_pkg::WK_SCAN_CODE_OFS: rd_data_q <= scan_code_q;
        wk_pkg::WK_SLOW_CFG_OFS:  rd_data_q <= {6'h00, slow_cfg_q};
        default:                  rd_data_q <= 8'h00;
      endcase
    end
  end

  assign reg_rd_data = rd_data_q;

  // Line synchronisers; the first stage feeds only the second
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      kclk_meta_q <= 1'b1;
      kclk_sync_q <= 1'b1;
      kdat_meta_q <= 1'b1;
      kdat_sync_q <= 1'b1;
    end
    else
    begin
      kclk_meta_q <= kbd_clk_in;
      kclk_sync_q <= kclk_meta_q;
      kdat_meta_q <= kbd_data_in;
      kdat_sync_q <= kdat_meta_q;
    end
  end

  // Lines resampled at the slow tick, so edges and high time are
  // seen with slow-clock resolution only
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      kclk_s_q    <= 1'b1;
      kdat_s_q    <= 1'b1;
      kclk_prev_q <= 1'b1;
    end
    else if (tick)
    begin
      kclk_s_q    <= kclk_sync_q;
      kdat_s_q    <= kdat_sync_q;
      kclk_prev_q <= kclk_s_q;
    end
  end

  assign fall = tick && kclk_prev_q && !kclk_s_q;

  // High-time counter saturates; any low level clears it
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      high_cnt_q <= 4'h0;
    else if (tick)
    begin
      if (!kclk_s_q)
        high_cnt_q <= 4'h0;
      else if (high_cnt_q != 4'hf)
        high_cnt_q <= high_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q    <= wk_pkg::WK_IDLE;
      edge_cnt_q <= 4'h0;
    end
    else if (code_wr || !run)
    begin
      state_q    <= wk_pkg::WK_IDLE;
      edge_cnt_q <= 4'h0;
    end
    else
    begin
      unique case (state_q)
        wk_pkg::WK_IDLE:
          if (high_cnt_q >= 4'(wk_pkg::WK_IDLE_HIGH_TICKS))
            state_q <= wk_pkg::WK_ARMED;
        wk_pkg::WK_ARMED:
          if (fall)
          begin
            state_q    <= wk_pkg::WK_RECV;
            edge_cnt_q <= 4'h1;
          end
        wk_pkg::WK_RECV:
          if (fall)
          begin
            if (edge_cnt_q == wk_pkg::WK_FRAME_BITS - 4'h1)
            begin
              state_q    <= wk_pkg::WK_IDLE;
              edge_cnt_q <= 4'h0;
            end
            else
              edge_cnt_q <= edge_cnt_q + 4'h1;
          end
          else if (high_cnt_q > 4'(wk_pkg::WK_ABORT_HIGH_TICKS))
          begin
            state_q    <= wk_pkg::WK_IDLE;
            edge_cnt_q <= 4'h0;
          end
        default:
        begin
          state_q    <= wk_pkg::WK_IDLE;
          edge_cnt_q <= 4'h0;
        end
      endcase
    end
  end

  // Edge numbers: 1 start, 2..9 data LSB first, 10 parity, 11 stop;
  // the counter still holds the previous edge number as an edge lands
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      data_q       <= 8'h00;
      byte_match_q <= 1'b0;
      parity_q     <= 1'b0;
    end
    else if (state_q == wk_pkg::WK_RECV && fall)
    begin
      if (edge_cnt_q < wk_pkg::WK_LAST_DATA_EDGE - 4'h1)
        data_q <= {kdat_s_q, data_q[7:1]};
      else if (edge_cnt_q == wk_pkg::WK_LAST_DATA_EDGE - 4'h1)
      begin
        data_q       <= {kdat_s_q, data_q[7:1]};
        byte_match_q <= {kdat_s_q, data_q[7:1]} == scan_code_q;
      end
      else if (edge_cnt_q == wk_pkg::WK_PARITY_EDGE - 4'h1)
        parity_q <= ^{kdat_s_q, data_q};
    end
  end

  // Evaluated on the stop-bit edge, one keyboard clock after parity
  assign frame_ok = state_q == wk_pkg::WK_RECV && fall
                    && edge_cnt_q == wk_pkg::WK_PARITY_EDGE
                    && byte_match_q && parity_q && kdat_s_q;

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      key_status_q <= 1'b0;
    else if (frame_ok)
      key_status_q <= 1'b1;
    else if (key_status_clear)
      key_status_q <= 1'b0;
  end

  assign key_pending = key_status_q && key_wake_enable;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      summary_q <= 1'b0;
    else if (key_pending || other_wake_pending)
      summary_q <= 1'b1;
    else if (summary_clear)
      summary_q <= 1'b0;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      wake_q <= 1'b0;
    else
      wake_q <= wake_global_enable && (key_pending || other_wake_pending);
  end

  assign key_match_status    = key_status_q;
  assign wake_summary_status = summary_q;
  assign wake_event_out      = wake_q;

endmodule : wk_matcher
`default_nettype wire

// ### test/wk_matcher_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module wk_matcher_assertions (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic       key_wake_enable,
  input wire logic       key_status_clear,
  input wire logic       other_wake_pending,
  input wire logic       wake_global_enable,
  input wire logic       key_match_status,
  input wire logic       wake_summary_status,
  input wire logic       wake_event_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_event_cause;
    wake_event_out |-> $past(wake_global_enable && (key_match_status && key_wake_enable || other_wake_pending));
  endproperty
  a_event_cause: assert property (p_event_cause) else $error("wake event without cause");
  property p_event_set;
    wake_global_enable && key_match_status && key_wake_enable |=> wake_event_out;
  endproperty
  a_event_set: assert property (p_event_set) else $error("enabled key match gave no wake event");
  property p_status_sticky;
    key_match_status && !key_status_clear |=> key_match_status;
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("key status dropped uncleared");
  property p_summary_set;
    key_match_status && key_wake_enable |-> ##[0:2] wake_summary_status;
  endproperty
  a_summary_set: assert property (p_summary_set) else $error("summary not set by key source");
  property p_summary_hold;
    wake_summary_status && other_wake_pending |=> wake_summary_status;
  endproperty
  a_summary_hold: assert property (p_summary_hold) else $error("summary cleared while pending");
  property p_unmapped_rd;
    reg_rd_en && !(reg_addr inside {8'h5f, 8'hf0}) |=> reg_rd_data == 8'h00;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
  property p_cfg_upper;
    reg_rd_en && reg_addr == 8'hf0 |=> reg_rd_data[7:2] == 6'h00;
  endproperty
  a_cfg_upper: assert property (p_cfg_upper) else $error("config upper bits not zero");
  property p_rd_hold;
    !reg_rd_en |=> $stable(reg_rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed without read");
endmodule : wk_matcher_assertions
bind wk_matcher wk_matcher_assertions chk_u (.core_clk, .rst, .reg_addr, .reg_rd_en, .reg_rd_data,
  .key_wake_enable, .key_status_clear, .other_wake_pending, .wake_global_enable, .key_match_status,
  .wake_summary_status, .wake_event_out);
`default_nettype wire

// ### test/wk_kbd_model.sv
`timescale 1ns/100ps
`default_nettype none
module wk_kbd_model #(
  parameter int HALF = 24
) (
  input  wire logic core_clk,
  output logic      kbd_clk,
  output logic      kbd_data
);
  initial
  begin
    kbd_clk = 1'b1;
    kbd_data = 1'b1;
  end
  task automatic send(input logic [7:0] c, input logic flip, input logic stop, input int falls);
    logic [10:0] f;
    f = {stop, ~(^c) ^ flip, c, 1'b0};
    repeat (HALF * 6) @(posedge core_clk);
    for (int i = 0; i < falls; i++)
    begin
      kbd_data <= f[i];
      repeat (HALF) @(posedge core_clk);
      kbd_clk <= 1'b0;
      repeat (HALF) @(posedge core_clk);
      kbd_clk <= 1'b1;
    end
    // Data line is pulled up once released
    kbd_data <= 1'b1;
    repeat (HALF * 4) @(posedge core_clk);
  endtask : send
endmodule : wk_kbd_model
`default_nettype wire

// ### test/wk_matcher_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module wk_matcher_tb_top;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data, rv, scan, code;
  logic       reg_wr_en = 1'b0, reg_rd_en = 1'b0, kbd_clk_in, kbd_data_in, ext_slow_clk = 1'b0, flip;
  logic       main_power_present = 1'b1, key_wake_enable = 1'b1, key_status_clear = 1'b0;
  logic       other_wake_pending = 1'b0, wake_global_enable = 1'b1, summary_clear = 1'b0;
  logic       key_match_status, wake_summary_status, wake_event_out;
  int         error_cnt = 0, check_count = 0, cyc = 0;
  wk_matcher dut_u (.core_clk, .rst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data, .kbd_clk_in,
    .kbd_data_in, .ext_slow_clk, .main_power_present, .key_wake_enable, .key_status_clear, .other_wake_pending,
    .wake_global_enable, .summary_clear, .key_match_status, .wake_summary_status, .wake_event_out);
  wk_kbd_model #(.HALF(24)) kbd_u (.core_clk(core_clk), .kbd_clk(kbd_clk_in), .kbd_data(kbd_data_in));
  always #20 core_clk = ~core_clk;
  // Slow clock sped up to one tick per 8 cycles so frames stay short
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3)
      ext_slow_clk <= ~ext_slow_clk;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test;
    end
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    @(negedge core_clk);
    rv = reg_rd_data;
  endtask : rd
  task automatic clr(input logic key);
    @(posedge core_clk);
    key_status_clear <= key;
    summary_clear <= ~key;
    @(posedge core_clk);
    key_status_clear <= 1'b0;
    summary_clear <= 1'b0;
    repeat (3) @(negedge core_clk);
  endtask : clr
  function automatic logic [7:0] hit(input logic [7:0] c, input logic f);
    return {7'h00, c === scan && !f};
  endfunction : hit
  task automatic frame(input string n, input logic [7:0] c, input logic f, input logic s, input logic [7:0] e);
    clr(1'b1);
    kbd_u.send(c, f, s, 11);
    @(negedge core_clk);
    chk(n, e, {7'h00, key_match_status});
    $display("test %s done", n);
  endtask : frame
  initial
  begin
    rv = $urandom(32'hf36596b7);
    scan = 8'($urandom);
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h5f);
    chk("scan_reset", 8'h00, rv);
    rd(8'hf0);
    chk("cfg_reset", 8'h00, rv);
    rd(8'h3c);
    chk("unmapped", 8'h00, rv);
    wr(8'hf0, 8'hfd);
    rd(8'hf0);
    chk("cfg_rw", 8'h01, rv);
    wr(8'h5f, scan);
    rd(8'h5f);
    chk("scan_rw", scan, rv);
    $display("test regs done");
    frame("match", scan, 1'b0, 1'b1, 8'h01);
    chk("event", 8'h01, {7'h00, wake_event_out});
    clr(1'b0);
    chk("summary_held", 8'h01, {7'h00, wake_summary_status});
    clr(1'b1);
    clr(1'b0);
    chk("summary_clear", 8'h00, {7'h00, wake_summary_status});
    $display("test summary done");
    frame("bad_parity", scan, 1'b1, 1'b1, 8'h00);
    frame("bad_stop", scan, 1'b0, 1'b0, 8'h00);
    clr(1'b1);
    // Code rewritten in mid-frame: the rest of the frame must not match
    fork
      kbd_u.send(scan, 1'b0, 1'b1, 11);
      begin
        repeat (400) @(posedge core_clk);
        wr(8'h5f, scan);
      end
    join
    @(negedge core_clk);
    chk("code_write_abort", 8'h00, {7'h00, key_match_status});
    $display("test code_write_abort done");
    kbd_u.send(scan, 1'b0, 1'b1, 6);
    frame("after_abort", scan, 1'b0, 1'b1, 8'h01);
    @(posedge core_clk);
    wake_global_enable <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk("no_global", 8'h02, {6'h00, wake_summary_status, wake_event_out});
    @(posedge core_clk);
    wake_global_enable <= 1'b1;
    key_wake_enable <= 1'b0;
    other_wake_pending <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk("other_src", 8'h01, {7'h00, wake_event_out});
    @(posedge core_clk);
    other_wake_pending <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk("key_disabled", 8'h00, {7'h00, wake_event_out});
    $display("test wake done");
    @(posedge core_clk);
    key_wake_enable <= 1'b1;
    wr(8'hf0, 8'hff);
    rd(8'hf0);
    chk("cfg_upper", 8'h03, rv);
    frame("off", scan, 1'b0, 1'b1, 8'h00);
    @(posedge core_clk);
    main_power_present <= 1'b0;
    wr(8'hf0, 8'h00);
    frame("standby", scan, 1'b0, 1'b1, 8'h01);
    @(posedge core_clk);
    main_power_present <= 1'b1;
    wr(8'hf0, 8'h01);
    for (int i = 0; i < 6; i++)
    begin
      code = ($urandom % 2) ? scan : 8'($urandom);
      flip = ($urandom % 4) == 0;
      frame("random", code, flip, 1'b1, hit(code, flip));
    end
    end_of_test;
  end
endmodule : wk_matcher_tb_top
`default_nettype wire
